/* hdl/prc_pkg.sv */
// Function
// - Reset registers A and B sit at offsets 0x040 and 0x044 of block base.
// - Both registers are 32 bits and clear to zero on reset.
// - Writes are masked by the matching capability word, A and B.
// - Register A bit 16 resets converter module zero.
// - Register A bit 3 resets the watchdog unit.
// - Register A bits 31:17, 15:4, 2:0 are read-only zero.
// - Register B bits 18, 17, 16 reset timers two, one and zero.
// - Register B bits 1 and 0 reset serial ports one and zero.
package prc_pkg;
    localparam logic [31:0] PRC_BLOCK_BASE = 32'h400fe000;
    localparam logic [11:0] PRC_OFF_CTRL_A = 12'h040;
    localparam logic [11:0] PRC_OFF_CTRL_B = 12'h044;
    localparam logic [31:0] PRC_RESET_VAL = 32'h00000000;
    // Writable bits of each register; all other bits are read-only zero.
    localparam logic [31:0] PRC_WMASK_A = 32'h00010008;
    localparam logic [31:0] PRC_WMASK_B = 32'h01071013;
    localparam int PRC_BIT_CONV0 = 16;
    localparam int PRC_BIT_WDOG = 3;
    localparam int PRC_BIT_COMPARATOR_ZERO_RESET_BIT = 24;
    localparam int PRC_BIT_TMR2 = 18;
    localparam int PRC_BIT_TMR1 = 17;
    localparam int PRC_BIT_TMR0 = 16;
    localparam int PRC_BIT_TWI0 = 12;
    localparam int PRC_BIT_SSER0 = 4;
    localparam int PRC_BIT_SP1 = 1;
    localparam int PRC_BIT_SP0 = 0;

    // One bus write as seen by a register.
    typedef struct packed {
        logic wr;
        logic [31:0] data;
    } prc_wr_s;

    // Per-peripheral reset outputs.
    typedef struct packed {
        logic adc_zero;
        logic watchdog_reset_bit;
        logic comparator_zero_reset_bit;
        logic gp_timer_two_reset_bit;
        logic gp_timer_one_reset_bit;
        logic gp_timer_zero_reset_bit;
        logic two_wire_zero_reset_bit;
        logic sync_serial_zero_reset_bit;
        logic serial_port_one_reset_bit;
        logic serial_port_zero_reset_bit;
    } prc_resets_s;
endpackage

/* hdl/prc_reg.sv */
`timescale 1ns/1ps
// One reset-control register with fixed writable bits and a capability mask.
module prc_reg
    import prc_pkg::*;
#(
    parameter logic [31:0] WMASK = 32'h00000000
)
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input prc_wr_s wr_i,
    input wire logic [31:0] cap_i,
    output logic [31:0] q_o
);
    logic [31:0] keep_mask;
    logic [31:0] next_q;

    // Only bits both implemented here and present in the capability word change.
    assign keep_mask = WMASK & cap_i;
    assign next_q = (q_o & ~keep_mask) | (wr_i.data & keep_mask);

    // The register clears on reset so nothing starts held in reset.
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            q_o <= PRC_RESET_VAL;
        else if (wr_i.wr)
            q_o <= next_q;
    end

    property p_ro_zero;
        @(posedge clk_i) disable iff (!reset_n_i)
        (q_o & ~WMASK) == 32'h00000000;
    endproperty
    a_ro_zero: assert property (p_ro_zero) else $error("read-only bit set");

    property p_masked_write;
        @(posedge clk_i) disable iff (!reset_n_i)
        wr_i.wr |=> (q_o & WMASK & $past(cap_i)) == ($past(wr_i.data) & WMASK & $past(cap_i));
    endproperty
    a_masked_write: assert property (p_masked_write) else $error("masked write lost");

    property p_unmasked_hold;
        @(posedge clk_i) disable iff (!reset_n_i)
        wr_i.wr |=> (q_o & ~($past(cap_i) & WMASK)) == ($past(q_o) & ~($past(cap_i) & WMASK));
    endproperty
    a_unmasked_hold: assert property (p_unmasked_hold) else $error("masked bit changed");

    property p_idle_hold;
        @(posedge clk_i) disable iff (!reset_n_i)
        !wr_i.wr |=> $stable(q_o);
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("register changed without write");
endmodule

/* hdl/prc_top.sv */
// Our own choice: the strobed register port.
`timescale 1ns/1ps
// Peripheral software reset control: two registers whose bits hold units in reset.
module prc_top
    import prc_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [11:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] capability_mask_a_i,
    input wire logic [31:0] capability_mask_b_i,
    output logic [31:0] rdata_o,
    output prc_resets_s resets_o
);
    logic sel_a;
    logic sel_b;
    prc_wr_s wr_a;
    prc_wr_s wr_b;
    logic [31:0] peripheral_reset_ctrl_a;
    logic [31:0] peripheral_reset_ctrl_b;
    logic [31:0] next_rdata;
    prc_resets_s next_resets;

    // Address decode of the two words within the block.
    assign sel_a = (addr_i == PRC_OFF_CTRL_A);
    assign sel_b = (addr_i == PRC_OFF_CTRL_B);
    assign wr_a = '{wr: wr_i & sel_a, data: wdata_i};
    assign wr_b = '{wr: wr_i & sel_b, data: wdata_i};

    prc_reg #(
        .WMASK(PRC_WMASK_A)
    ) u_reg_a (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .wr_i(wr_a),
        .cap_i(capability_mask_a_i),
        .q_o(peripheral_reset_ctrl_a)
    );

    prc_reg #(
        .WMASK(PRC_WMASK_B)
    ) u_reg_b (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .wr_i(wr_b),
        .cap_i(capability_mask_b_i),
        .q_o(peripheral_reset_ctrl_b)
    );

    // Unmapped addresses read as zero rather than faulting.
    assign next_rdata = !rd_i ? 32'h00000000 :
                        sel_a ? peripheral_reset_ctrl_a :
                        sel_b ? peripheral_reset_ctrl_b : 32'h00000000;

    // Reset lines follow the register bits; registering them costs one cycle
    // but keeps glitches off the peripherals' reset inputs.
    assign next_resets.adc_zero = peripheral_reset_ctrl_a[PRC_BIT_CONV0];
    assign next_resets.watchdog_reset_bit = peripheral_reset_ctrl_a[PRC_BIT_WDOG];
    assign next_resets.comparator_zero_reset_bit = peripheral_reset_ctrl_b[PRC_BIT_COMPARATOR_ZERO_RESET_BIT];
    assign next_resets.gp_timer_two_reset_bit = peripheral_reset_ctrl_b[PRC_BIT_TMR2];
    assign next_resets.gp_timer_one_reset_bit = peripheral_reset_ctrl_b[PRC_BIT_TMR1];
    assign next_resets.gp_timer_zero_reset_bit = peripheral_reset_ctrl_b[PRC_BIT_TMR0];
    assign next_resets.two_wire_zero_reset_bit = peripheral_reset_ctrl_b[PRC_BIT_TWI0];
    assign next_resets.sync_serial_zero_reset_bit = peripheral_reset_ctrl_b[PRC_BIT_SSER0];
    assign next_resets.serial_port_one_reset_bit = peripheral_reset_ctrl_b[PRC_BIT_SP1];
    assign next_resets.serial_port_zero_reset_bit = peripheral_reset_ctrl_b[PRC_BIT_SP0];

    // Output flops for read data and reset lines.
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rdata_o <= 32'h00000000;
            resets_o <= '0;
        end
        else
        begin
            rdata_o <= next_rdata;
            resets_o <= next_resets;
        end
    end

    // A read returns the addressed register in the cycle after the strobe.
    property p_read_a;
        @(posedge clk_i) disable iff (!reset_n_i)
        (rd_i && sel_a) |=> rdata_o == $past(peripheral_reset_ctrl_a);
    endproperty
    a_read_a: assert property (p_read_a) else $error("read of register A wrong");

    // Register B decodes at its own offset and never aliases register A.
    property p_read_b;
        @(posedge clk_i) disable iff (!reset_n_i)
        (rd_i && sel_b) |=> rdata_o == $past(peripheral_reset_ctrl_b);
    endproperty
    a_read_b: assert property (p_read_b) else $error("read of register B wrong");

    // Read-only bits of register A come back as zero on every read.
    property p_read_a_ro;
        @(posedge clk_i) disable iff (!reset_n_i)
        (rd_i && sel_a) |=> (rdata_o & ~PRC_WMASK_A) == 32'h00000000;
    endproperty
    a_read_a_ro: assert property (p_read_a_ro) else $error("A read-only bit set");

    // Register B has read-only gaps between its groups of reset bits.
    property p_read_b_ro;
        @(posedge clk_i) disable iff (!reset_n_i)
        (rd_i && sel_b) |=> (rdata_o & ~PRC_WMASK_B) == 32'h00000000;
    endproperty
    a_read_b_ro: assert property (p_read_b_ro) else $error("B read-only bit set");

    // Any other offset in the block is not decoded and reads as zero.
    property p_read_unmapped;
        @(posedge clk_i) disable iff (!reset_n_i)
        (rd_i && !sel_a && !sel_b) |=> rdata_o == 32'h00000000;
    endproperty
    a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read");

    // Setting the watchdog bit must reach its reset line two edges later.
    property p_wdog_follow;
        @(posedge clk_i) disable iff (!reset_n_i)
        (wr_a.wr && wdata_i[PRC_BIT_WDOG] && capability_mask_a_i[PRC_BIT_WDOG])
            |=> ##1 resets_o.watchdog_reset_bit;
    endproperty
    a_wdog_follow: assert property (p_wdog_follow) else $error("watchdog reset not held");

    // Setting the converter bit must hold the converter in reset.
    property p_conv_set;
        @(posedge clk_i) disable iff (!reset_n_i)
        (wr_a.wr && wdata_i[PRC_BIT_CONV0] && capability_mask_a_i[PRC_BIT_CONV0])
            |=> ##1 resets_o.adc_zero;
    endproperty
    a_conv_set: assert property (p_conv_set) else $error("converter reset not held");

    // Clearing the watchdog bit must let the watchdog run again.
    property p_wdog_release;
        @(posedge clk_i) disable iff (!reset_n_i)
        (wr_a.wr && !wdata_i[PRC_BIT_WDOG] && capability_mask_a_i[PRC_BIT_WDOG])
            |=> ##1 !resets_o.watchdog_reset_bit;
    endproperty
    a_wdog_release: assert property (p_wdog_release) else $error("watchdog not released");

    // The converter line mirrors its register bit with one edge of delay.
    property p_conv_follow;
        @(posedge clk_i) disable iff (!reset_n_i)
        ##1 resets_o.adc_zero == $past(peripheral_reset_ctrl_a[PRC_BIT_CONV0]);
    endproperty
    a_conv_follow: assert property (p_conv_follow) else $error("converter reset mismatch");

    // The comparator line mirrors its register bit with one edge of delay.
    property p_comp_follow;
        @(posedge clk_i) disable iff (!reset_n_i)
        ##1 resets_o.comparator_zero_reset_bit
            == $past(peripheral_reset_ctrl_b[PRC_BIT_COMPARATOR_ZERO_RESET_BIT]);
    endproperty
    a_comp_follow: assert property (p_comp_follow) else $error("comparator reset mismatch");

    // Setting the comparator bit must hold the comparator in reset.
    property p_comp_set;
        @(posedge clk_i) disable iff (!reset_n_i)
        (wr_b.wr && wdata_i[PRC_BIT_COMPARATOR_ZERO_RESET_BIT] && capability_mask_b_i[PRC_BIT_COMPARATOR_ZERO_RESET_BIT])
            |=> ##1 resets_o.comparator_zero_reset_bit;
    endproperty
    a_comp_set: assert property (p_comp_set) else $error("comparator reset not held");

    // The three timer lines follow their register bits together.
    property p_timer_follow;
        @(posedge clk_i) disable iff (!reset_n_i)
        ##1 {resets_o.gp_timer_two_reset_bit, resets_o.gp_timer_one_reset_bit,
             resets_o.gp_timer_zero_reset_bit}
            == {$past(peripheral_reset_ctrl_b[PRC_BIT_TMR2]),
                $past(peripheral_reset_ctrl_b[PRC_BIT_TMR1]),
                $past(peripheral_reset_ctrl_b[PRC_BIT_TMR0])};
    endproperty
    a_timer_follow: assert property (p_timer_follow) else $error("timer reset mismatch");

    // Clearing the comparator bit must let the comparator run again.
    property p_release;
        @(posedge clk_i) disable iff (!reset_n_i)
        (wr_b.wr && !wdata_i[PRC_BIT_COMPARATOR_ZERO_RESET_BIT] && capability_mask_b_i[PRC_BIT_COMPARATOR_ZERO_RESET_BIT])
            |=> ##1 !resets_o.comparator_zero_reset_bit;
    endproperty
    a_release: assert property (p_release) else $error("comparator not released");

    // The four serial-unit lines follow their register bits together.
    property p_serial_follow;
        @(posedge clk_i) disable iff (!reset_n_i)
        ##1 {resets_o.two_wire_zero_reset_bit, resets_o.sync_serial_zero_reset_bit,
             resets_o.serial_port_one_reset_bit, resets_o.serial_port_zero_reset_bit}
            == {$past(peripheral_reset_ctrl_b[PRC_BIT_TWI0]),
                $past(peripheral_reset_ctrl_b[PRC_BIT_SSER0]),
                $past(peripheral_reset_ctrl_b[PRC_BIT_SP1]),
                $past(peripheral_reset_ctrl_b[PRC_BIT_SP0])};
    endproperty
    a_serial_follow: assert property (p_serial_follow) else $error("serial reset mismatch");

    // Setting the two-wire bit must hold that unit in reset.
    property p_twi_set;
        @(posedge clk_i) disable iff (!reset_n_i)
        (wr_b.wr && wdata_i[PRC_BIT_TWI0] && capability_mask_b_i[PRC_BIT_TWI0])
            |=> ##1 resets_o.two_wire_zero_reset_bit;
    endproperty
    a_twi_set: assert property (p_twi_set) else $error("two-wire reset not held");

    // Setting the serial port zero bit must hold that port in reset.
    property p_port_set;
        @(posedge clk_i) disable iff (!reset_n_i)
        (wr_b.wr && wdata_i[PRC_BIT_SP0] && capability_mask_b_i[PRC_BIT_SP0])
            |=> ##1 resets_o.serial_port_zero_reset_bit;
    endproperty
    a_port_set: assert property (p_port_set) else $error("serial port reset not held");

    // Without a write the lines may not move: a glitch would reset a live unit.
    property p_resets_hold;
        @(posedge clk_i) disable iff (!reset_n_i)
        !wr_i |=> ##1 $stable(resets_o);
    endproperty
    a_resets_hold: assert property (p_resets_hold) else $error("reset line moved");

    // While reset is low, and at the edge that releases it, nothing is held.
    property p_reset_clear;
        @(posedge clk_i)
        !reset_n_i |=> (resets_o == '0) && (rdata_o == 32'h00000000);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("output set after reset");

    // Read data is zero outside the cycle after a read strobe.
    property p_idle_read;
        @(posedge clk_i) disable iff (!reset_n_i)
        !rd_i |=> rdata_o == 32'h00000000;
    endproperty
    a_idle_read: assert property (p_idle_read) else $error("read data outside read");
endmodule

/* testbench/prc_bench.sv */
`timescale 1ns/1ps
// Drives the register port by hand and checks read-back and reset lines.
module prc_bench;
    import prc_pkg::*;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [11:0] addr_i = 12'h000;
    logic [31:0] wdata_i = 32'h00000000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [31:0] capability_mask_a_i = 32'hffffffff;
    logic [31:0] capability_mask_b_i = 32'hffffffff;
    logic [31:0] rdata_o;
    prc_resets_s resets_o;
    logic [31:0] got;
    int num_errors = 0;
    int n_compared = 0;

    prc_top dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .capability_mask_a_i(capability_mask_a_i),
        .capability_mask_b_i(capability_mask_b_i), .rdata_o(rdata_o), .resets_o(resets_o));

    // The clock toggles every 12.5 ns, half of its 25 ns period.
    initial
    begin
        forever #12.5 clk_i = ~clk_i;
    end

    task check(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want)
        begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task bus_write(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe, so it is taken there.
    task bus_read(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask

    // The reset lines trail the register by one edge, so two edges are allowed.
    task check_resets(input logic [31:0] a, input logic [31:0] b);
        repeat (2) @(posedge clk_i);
        #1 check({22'h0, resets_o}, {22'h0, a[16], a[3], b[24], b[18], b[17], b[16],
            b[12], b[4], b[1], b[0]});
    endtask

    task test_reset_values;
        bus_read(12'h040, got);
        check(got, 32'h00000000);
        bus_read(12'h044, got);
        check(got, 32'h00000000);
        check_resets(32'h0, 32'h0);
    endtask

    task test_reg_a;
        bus_write(12'h040, 32'hffffffff);
        bus_read(12'h040, got);
        check(got, 32'h00010008);
        bus_read(12'h044, got);
        check(got, 32'h00000000);
        check_resets(32'h00010008, 32'h0);
        bus_write(12'h040, 32'h00000000);
        check_resets(32'h0, 32'h0);
    endtask

    task test_reg_b;
        bus_write(12'h044, 32'hffffffff);
        bus_read(12'h044, got);
        check(got, 32'h01071013);
        check_resets(32'h0, 32'h01071013);
    endtask

    // Only bits whose capability bit is set may change.
    task test_masking;
        @(posedge clk_i);
        capability_mask_a_i <= 32'h00000008;
        capability_mask_b_i <= 32'h00010000;
        bus_write(12'h040, 32'hffffffff);
        bus_write(12'h044, 32'h00000000);
        bus_read(12'h040, got);
        check(got, 32'h00000008);
        bus_read(12'h044, got);
        check(got, 32'h01061013);
        check_resets(32'h00000008, 32'h01061013);
        // With every bit of B allowed again, clearing B releases all its units.
        @(posedge clk_i);
        capability_mask_b_i <= 32'hffffffff;
        bus_write(12'h044, 32'h00000000);
        bus_read(12'h044, got);
        check(got, 32'h00000000);
        check_resets(32'h00000008, 32'h0);
    endtask

    // A neighbouring offset is not decoded; a second reset clears everything.
    task test_unmapped_and_reset;
        bus_write(12'h048, 32'hffffffff);
        bus_read(12'h048, got);
        check(got, 32'h00000000);
        bus_read(12'h040, got);
        check(got, 32'h00000008);
        @(posedge clk_i);
        reset_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        reset_n_i <= 1'b1;
        bus_read(12'h044, got);
        check(got, 32'h00000000);
        check_resets(32'h0, 32'h0);
    endtask

    task finish_test;
        if (num_errors == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // The whole sequence needs well under a thousand cycles.
    initial
    begin
        #100000;
        num_errors++;
        finish_test();
    end

    initial
    begin
        repeat (20) @(posedge clk_i);
        reset_n_i <= 1'b1;
        test_reset_values();
        test_reg_a();
        test_reg_b();
        test_masking();
        test_unmapped_and_reset();
        finish_test();
    end
endmodule
